// >>> bench/tb_top.sv
// Purpose: Self-checking bench for the timer event status block
// Assumes: Zero-wait APB slave; count advances each cycle while run is set
// Notes:   Flags are polled on the status port under a bound
`timescale 1ns/1ps
`default_nettype none
`include "tes_cfg.svh"
module tb_top;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [3:0]  capture_strobe;
   logic        count_tick;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  timer_event_status;
   logic        wrap_interrupt_request;
   logic [3:0]  chan_interrupt_request;
   logic [31:0] rd;
   int          failures;
   int          tests_run;

   tes_status i_dut (
      .pclk                   (pclk),
      .presetn                (presetn),
      .psel                   (psel),
      .penable                (penable),
      .pwrite                 (pwrite),
      .paddr                  (paddr),
      .pwdata                 (pwdata),
      .capture_strobe         (capture_strobe),
      .count_tick             (count_tick),
      .prdata                 (prdata),
      .pready                 (pready),
      .pslverr                (pslverr),
      .timer_event_status     (timer_event_status),
      .wrap_interrupt_request (wrap_interrupt_request),
      .chan_interrupt_request (chan_interrupt_request)
   );

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("ERROR at %0t: seen %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : close_out

   // One APB transfer; read data lands in rd
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= addr;
      pwdata  <= wdata;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      check(32'(pslverr), 32'h0);
      rd = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wait_flags(input logic [7:0] exp);
      int n;
      n = 0;
      while (timer_event_status !== exp && n < 200) begin
         @(posedge pclk);
         n++;
      end
   endtask : wait_flags

   task automatic reset_values();
      apb(1'b0, `TES_OFF_STATUS, 32'h0);
      check(rd, 32'h0000_0070);
      apb(1'b1, `TES_OFF_STATUS, 32'h0000_00FF);
      apb(1'b0, `TES_OFF_STATUS, 32'h0);
      check(rd, 32'h0000_0070);
      apb(1'b0, 12'h040, 32'h0);
      check(rd, 32'h0);
      check(32'({wrap_interrupt_request, chan_interrupt_request}), 32'h0);
   endtask : reset_values

   // Read-then-write-zero clearing, after a bare zero write is refused
   task automatic clear_flags(input logic [7:0] held, input logic [7:0] kill);
      apb(1'b1, `TES_OFF_STATUS, 32'h0);
      wait_flags(held & ~kill);
      check(32'(timer_event_status), 32'(held));
      apb(1'b0, `TES_OFF_STATUS, 32'h0);
      check(rd, 32'(held));
      apb(1'b1, `TES_OFF_STATUS, 32'(~kill));
      wait_flags(held & ~kill);
      check(32'(timer_event_status), 32'(held & ~kill));
      check(32'(chan_interrupt_request), 32'(held[3:0] & ~kill[3:0]));
   endtask : clear_flags

   task automatic compare_flags();
      apb(1'b1, `TES_OFF_IEN, 32'h0000_00FF);
      apb(1'b1, `TES_OFF_GRA, 32'h0000_0010);
      apb(1'b1, `TES_OFF_GRB, 32'h0000_0011);
      apb(1'b1, `TES_OFF_GRC, 32'h0000_0012);
      apb(1'b1, `TES_OFF_GRD, 32'h0000_0013);
      apb(1'b1, `TES_OFF_SEL, 32'h0);
      apb(1'b1, `TES_OFF_COUNT, 32'h0);
      apb(1'b1, `TES_OFF_CTRL, 32'h1);
      wait_flags(8'h7F);
      apb(1'b1, `TES_OFF_CTRL, 32'h0);
      check(32'(timer_event_status), 32'h7F);
      check(32'(chan_interrupt_request), 32'hF);
      clear_flags(8'h7F, 8'h0F);
   endtask : compare_flags

   // A, B and D capture; C stays compare and must ignore its strobe
   task automatic capture_flags();
      apb(1'b1, `TES_OFF_SEL, 32'h0000_000B);
      apb(1'b1, `TES_OFF_COUNT, 32'h0000_1234);
      @(posedge pclk);
      capture_strobe <= 4'hF;
      @(posedge pclk);
      capture_strobe <= 4'h0;
      wait_flags(8'h7B);
      check(32'(timer_event_status), 32'h7B);
      apb(1'b0, `TES_OFF_GRB, 32'h0);
      check(rd, 32'h0000_1234);
      apb(1'b0, `TES_OFF_GRD, 32'h0);
      check(rd, 32'h0000_1234);
      apb(1'b0, `TES_OFF_GRA, 32'h0);
      check(rd, 32'h0000_1234);
      apb(1'b0, `TES_OFF_GRC, 32'h0);
      check(rd, 32'h0000_0012);
      clear_flags(8'h7B, 8'h0A);
   endtask : capture_flags

   // Channel A flag is still held from the capture scenario
   task automatic wrap_flag();
      apb(1'b1, `TES_OFF_COUNT, 32'h0000_FFF8);
      apb(1'b1, `TES_OFF_CTRL, 32'h1);
      wait_flags(8'hF1);
      apb(1'b1, `TES_OFF_CTRL, 32'h0);
      check(32'(timer_event_status), 32'hF1);
      check(32'(wrap_interrupt_request), 32'h1);
      clear_flags(8'hF1, 8'h81);
      check(32'(wrap_interrupt_request), 32'h0);
   endtask : wrap_flag

   initial begin
      failures       = 0;
      tests_run      = 0;
      presetn        = 1'b0;
      psel           = 1'b0;
      penable        = 1'b0;
      pwrite         = 1'b0;
      paddr          = 12'h000;
      pwdata         = 32'h0;
      capture_strobe = 4'h0;
      count_tick     = 1'b1;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      reset_values();
      compare_flags();
      capture_flags();
      wrap_flag();
      close_out();
   end

   // Whole run is about 730 cycles
   initial begin
      #20000;
      failures++;
      close_out();
   end
endmodule : tb_top
`default_nettype wire

// >>> shared/tes_cfg.svh
// Purpose: Constants for the timer event status block
// Assumes: APB word addressing, registers of up to 16 bits in the low bits
// Notes:   Definitions only
`ifndef TES_CFG_SVH
`define TES_CFG_SVH

`define TES_OFF_STATUS    12'h000
`define TES_OFF_IEN       12'h004
`define TES_OFF_SEL       12'h008
`define TES_OFF_COUNT     12'h00C
`define TES_OFF_GRA       12'h010
`define TES_OFF_GRB       12'h014
`define TES_OFF_GRC       12'h018
`define TES_OFF_GRD       12'h01C
`define TES_OFF_CTRL      12'h020

`define TES_BIT_WRAP      7
`define TES_RSVD_MASK     8'h70
`define TES_STATUS_RESET  8'h70
`define TES_IEN_WRAP      7
`define TES_CTRL_RUN      0
`define TES_COUNT_MAX     16'hFFFF
`define TES_GR_RESET      16'hFFFF

`endif

// >>> shared/tes_pkg.sv
// Purpose: Types for the timer event status block
// Assumes: Constants come from tes_cfg.svh
// Notes:   Types only
package tes_pkg;
   typedef enum logic [1:0] {
      TES_ACC_IDLE  = 2'b00,
      TES_ACC_SETUP = 2'b01,
      TES_ACC_DONE  = 2'b10
   } tes_acc_t;
   typedef logic [15:0] tes_word_t;
endpackage : tes_pkg

// >>> verilog/tes_channel.sv
// Purpose: One general register acting as compare or capture
// Assumes: Capture strobe is a one-cycle pulse, already edge-selected
// Notes:   Event is a one-cycle pulse one clock after the cause
`timescale 1ns/1ps
`default_nettype none
module tes_channel #(
   parameter int WIDTH = 16
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             capture_sel,
   input  wire logic             capture_strobe,
   input  wire logic [WIDTH-1:0] timer_count_value,
   input  wire logic             wr_en,
   input  wire logic [WIDTH-1:0] wr_value,
   output logic      [WIDTH-1:0] general_reg,
   output logic                  event_pulse
);
   logic match;
   logic match_q;

   initial begin
      if (WIDTH < 2 || WIDTH > 32) begin
         $error("tes_channel WIDTH out of range");
      end
   end

   assign match = !capture_sel && (timer_count_value == general_reg);

   // Capture loads the count; in compare mode software owns the value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         general_reg <= {WIDTH{1'b1}};
      end else if (capture_sel && capture_strobe) begin
         general_reg <= timer_count_value;
      end else if (wr_en) begin
         general_reg <= wr_value;
      end
   end

   // One pulse per match entry, so a stopped count does not re-fire
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         match_q     <= 1'b0;
         event_pulse <= 1'b0;
      end else begin
         match_q     <= match;
         event_pulse <= (match && !match_q) || (capture_sel && capture_strobe);
      end
   end
endmodule : tes_channel
`default_nettype wire

// >>> verilog/tes_counter.sv
// Purpose: Free-running 16-bit timer count with wrap pulse
// Assumes: Count enable is a one-cycle pulse or level from a divider
// Notes:   Software may load the count while counting is stopped
`timescale 1ns/1ps
`default_nettype none
module tes_counter #(
   parameter int WIDTH = 16
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             count_en,
   input  wire logic             load_en,
   input  wire logic [WIDTH-1:0] load_value,
   output logic      [WIDTH-1:0] timer_count_value,
   output logic                  wrap_pulse
);
   initial begin
      if (WIDTH < 2 || WIDTH > 32) begin
         $error("tes_counter WIDTH out of range");
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_count_value <= '0;
      end else if (load_en) begin
         timer_count_value <= load_value;
      end else if (count_en) begin
         timer_count_value <= timer_count_value + 1'b1;
      end
   end

   // Wrap from all ones to zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wrap_pulse <= 1'b0;
      end else begin
         wrap_pulse <= count_en && !load_en && (&timer_count_value);
      end
   end
endmodule : tes_counter
`default_nettype wire

// >>> verilog/tes_status.sv
// Purpose: Timer status flags with read-then-write-zero clearing, on APB
// Assumes: Capture strobes arrive edge-selected; counting paced by count_tick
// Notes:   Zero-wait APB slave, unmapped addresses read zero, pslverr low
//
// Functional notes
// - Counter wrap sets bit 7 flag
// - Wrap flag clears by read-1 then write-0
// - Bits 6..4 read one, ignore writes
// - Channel D compare match sets bit 3
// - Channel D capture loads count, sets flag
// - Channel D flag clears by read-1, write-0
// - Channel C compare match sets bit 2
// - Channel C capture loads count, sets flag
// - Channel C flag clears by read-1, write-0
// - Channel B compare match sets bit 1
// - Channel B capture loads count, sets flag
// - Channel B flag clears by read-1, write-0
// - Channel A compare match sets bit 0
// - Channel A capture loads count, sets flag
// - Channel A flag clears by read-1, write-0
// - Wrap request when flag and enable set
// - Channel request when flag and enable set
// - Select bit: zero compare, one capture
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "tes_cfg.svh"
module tes_status (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  capture_strobe,
   input  wire logic        count_tick,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic      [7:0]  timer_event_status,
   output logic             wrap_interrupt_request,
   output logic      [3:0]  chan_interrupt_request
);
   logic [3:0]        chan_event_flag;
   logic              counter_wrap_flag;
   logic [4:0]        read_armed;
   logic [7:0]        interrupt_enable;
   logic [3:0]        capture_select;
   logic              run;
   tes_pkg::tes_word_t timer_count_value;
   tes_pkg::tes_word_t general_reg [4];
   logic              wrap_pulse;
   logic [3:0]        chan_event;
   logic [3:0]        gr_wr;
   logic              acc;
   logic              wr;
   logic              rd;
   logic [4:0]        next_flags;
   logic [4:0]        set_vec;
   logic [4:0]        clr_vec;
   logic [7:0]        status_view;
   logic [31:0]       next_prdata;
   logic [7:0]        next_ien;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a == off);
   endfunction : hit

   assign acc = psel && penable && pready;
   assign wr  = acc && pwrite;
   assign rd  = acc && !pwrite;

   assign status_view = {counter_wrap_flag, 3'b111, chan_event_flag};

   tes_counter #(.WIDTH(16)) u_counter (
      .pclk              (pclk),
      .presetn           (presetn),
      .count_en          (run && count_tick),
      .load_en           (wr && hit(paddr, `TES_OFF_COUNT)),
      .load_value        (pwdata[15:0]),
      .timer_count_value (timer_count_value),
      .wrap_pulse        (wrap_pulse)
   );

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_chan
         assign gr_wr[g] = wr && hit(paddr, 12'(`TES_OFF_GRA + 4 * g));
         tes_channel #(.WIDTH(16)) u_chan (
            .pclk              (pclk),
            .presetn           (presetn),
            .capture_sel       (capture_select[g]),
            .capture_strobe    (capture_strobe[g]),
            .timer_count_value (timer_count_value),
            .wr_en             (gr_wr[g]),
            .wr_value          (pwdata[15:0]),
            .general_reg       (general_reg[g]),
            .event_pulse       (chan_event[g])
         );
      end
   endgenerate

   assign set_vec = {wrap_pulse, chan_event};

   always_comb begin
      clr_vec = '0;
      if (wr && hit(paddr, `TES_OFF_STATUS)) begin
         clr_vec = read_armed & ~{pwdata[`TES_BIT_WRAP], pwdata[3:0]};
      end
      next_flags = ({counter_wrap_flag, chan_event_flag} & ~clr_vec) | set_vec;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         counter_wrap_flag <= 1'b0;
         chan_event_flag   <= 4'h0;
      end else begin
         counter_wrap_flag <= next_flags[4];
         chan_event_flag   <= next_flags[3:0];
      end
   end

   // Arm on a read showing one; drop on a status write or new set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         read_armed <= 5'h00;
      end else if (wr && hit(paddr, `TES_OFF_STATUS)) begin
         read_armed <= 5'h00;
      end else if (rd && hit(paddr, `TES_OFF_STATUS)) begin
         // Arm from the returned word: a flag set after setup stays unarmed
         read_armed <= {prdata[`TES_BIT_WRAP], prdata[3:0]} & ~set_vec;
      end else begin
         read_armed <= read_armed & ~set_vec;
      end
   end

   // Enable value after this edge, so requests track flags and enables together
   always_comb begin
      next_ien = interrupt_enable;
      if (wr && hit(paddr, `TES_OFF_IEN)) begin
         next_ien = (pwdata[7:0] & 8'h8F) | `TES_RSVD_MASK;
      end
   end

   // Control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         interrupt_enable <= `TES_RSVD_MASK;
         capture_select   <= 4'h0;
         run              <= 1'b0;
      end else if (wr) begin
         if (hit(paddr, `TES_OFF_IEN)) begin
            interrupt_enable <= next_ien;
         end
         if (hit(paddr, `TES_OFF_SEL)) begin
            capture_select <= pwdata[3:0];
         end
         if (hit(paddr, `TES_OFF_CTRL)) begin
            run <= pwdata[`TES_CTRL_RUN];
         end
      end
   end

   always_comb begin
      next_prdata = 32'h0000_0000;
      unique case (1'b1)
         hit(paddr, `TES_OFF_STATUS): next_prdata = {24'h0, status_view};
         hit(paddr, `TES_OFF_IEN):    next_prdata = {24'h0, interrupt_enable};
         hit(paddr, `TES_OFF_SEL):    next_prdata = {28'h0, capture_select};
         hit(paddr, `TES_OFF_COUNT):  next_prdata = {16'h0, timer_count_value};
         hit(paddr, `TES_OFF_GRA):    next_prdata = {16'h0, general_reg[0]};
         hit(paddr, `TES_OFF_GRB):    next_prdata = {16'h0, general_reg[1]};
         hit(paddr, `TES_OFF_GRC):    next_prdata = {16'h0, general_reg[2]};
         hit(paddr, `TES_OFF_GRD):    next_prdata = {16'h0, general_reg[3]};
         hit(paddr, `TES_OFF_CTRL):   next_prdata = {31'h0, run};
         default:                     next_prdata = 32'h0000_0000;
      endcase
   end

   // Read data registered in the setup cycle, ready in the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         if (psel && !penable && !pwrite) begin
            prdata <= next_prdata;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wrap_interrupt_request <= 1'b0;
         chan_interrupt_request <= 4'h0;
         timer_event_status     <= `TES_STATUS_RESET;
      end else begin
         wrap_interrupt_request <= next_flags[4] && next_ien[`TES_IEN_WRAP];
         chan_interrupt_request <= next_flags[3:0] & next_ien[3:0];
         timer_event_status     <= {next_flags[4], 3'b111, next_flags[3:0]};
      end
   end

   wire [4:0] flags_now = {counter_wrap_flag, chan_event_flag};

   wrap_sets_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
      wrap_pulse |=> counter_wrap_flag)
      else $error("wrap did not set flag");
   rsvd_reads_one_a: assert property (@(posedge pclk) disable iff (!presetn)
      timer_event_status[6:4] == 3'b111)
      else $error("reserved status bits not one");
   unarmed_no_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && hit(paddr, `TES_OFF_STATUS) && read_armed == 5'h00)
      |=> flags_now == ($past(flags_now) | $past(set_vec)))
      else $error("flag cleared without prior read");
   set_beats_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      set_vec[0] |=> chan_event_flag[0])
      else $error("channel A set lost");
   chan_irq_follows_a: assert property (@(posedge pclk) disable iff (!presetn)
      chan_interrupt_request == (chan_event_flag & interrupt_enable[3:0]))
      else $error("channel request mismatch");
   wrap_irq_follows_a: assert property (@(posedge pclk) disable iff (!presetn)
      wrap_interrupt_request == (counter_wrap_flag && interrupt_enable[7]))
      else $error("wrap request mismatch");
   armed_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && hit(paddr, `TES_OFF_STATUS) && read_armed[4] && !pwdata[7] && !wrap_pulse)
      |=> !counter_wrap_flag)
      else $error("armed wrap clear failed");
   capture_loads_a: assert property (@(posedge pclk) disable iff (!presetn)
      (capture_select[0] && capture_strobe[0]) |=> general_reg[0] == $past(timer_count_value)
      ##1 chan_event_flag[0])
      else $error("capture A did not load");
   compare_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!capture_select[0] && timer_count_value == general_reg[0] && run && count_tick)
      |-> ##[1:2] chan_event_flag[0])
      else $error("compare A did not set flag");
   compare_sets_b_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!capture_select[1] && timer_count_value == general_reg[1] && run && count_tick)
      |-> ##[1:2] chan_event_flag[1])
      else $error("compare B did not set flag");
   compare_sets_c_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!capture_select[2] && timer_count_value == general_reg[2] && run && count_tick)
      |-> ##[1:2] chan_event_flag[2])
      else $error("compare C did not set flag");
   compare_sets_d_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!capture_select[3] && timer_count_value == general_reg[3] && run && count_tick)
      |-> ##[1:2] chan_event_flag[3])
      else $error("compare D did not set flag");
   capture_loads_b_a: assert property (@(posedge pclk) disable iff (!presetn)
      (capture_select[1] && capture_strobe[1]) |=> general_reg[1] == $past(timer_count_value)
      ##1 chan_event_flag[1])
      else $error("capture B did not load");
   capture_loads_c_a: assert property (@(posedge pclk) disable iff (!presetn)
      (capture_select[2] && capture_strobe[2]) |=> general_reg[2] == $past(timer_count_value)
      ##1 chan_event_flag[2])
      else $error("capture C did not load");
   capture_loads_d_a: assert property (@(posedge pclk) disable iff (!presetn)
      (capture_select[3] && capture_strobe[3]) |=> general_reg[3] == $past(timer_count_value)
      ##1 chan_event_flag[3])
      else $error("capture D did not load");
   flag_d_held_a: assert property (@(posedge pclk) disable iff (!presetn)
      (chan_event_flag[3] && !(wr && hit(paddr, `TES_OFF_STATUS) && read_armed[3] && !pwdata[3]))
      |=> chan_event_flag[3])
      else $error("flag D cleared without armed zero write");
   flag_c_held_a: assert property (@(posedge pclk) disable iff (!presetn)
      (chan_event_flag[2] && !(wr && hit(paddr, `TES_OFF_STATUS) && read_armed[2] && !pwdata[2]))
      |=> chan_event_flag[2])
      else $error("flag C cleared without armed zero write");
   flag_b_held_a: assert property (@(posedge pclk) disable iff (!presetn)
      (chan_event_flag[1] && !(wr && hit(paddr, `TES_OFF_STATUS) && read_armed[1] && !pwdata[1]))
      |=> chan_event_flag[1])
      else $error("flag B cleared without armed zero write");
   flag_a_held_a: assert property (@(posedge pclk) disable iff (!presetn)
      (chan_event_flag[0] && !(wr && hit(paddr, `TES_OFF_STATUS) && read_armed[0] && !pwdata[0]))
      |=> chan_event_flag[0])
      else $error("flag A cleared without armed zero write");
   ready_one_cycle_a: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> pready ##1 !pready)
      else $error("pready timing");

   wrap_seen_c: cover property (@(posedge pclk) disable iff (!presetn) wrap_pulse);
   clear_seen_c: cover property (@(posedge pclk) disable iff (!presetn) clr_vec != 5'h00);
   capture_seen_c: cover property (@(posedge pclk) disable iff (!presetn)
      capture_select[3] && capture_strobe[3]);
   race_seen_c: cover property (@(posedge pclk) disable iff (!presetn)
      (clr_vec & set_vec) != 5'h00);
   compare_seen_c: cover property (@(posedge pclk) disable iff (!presetn)
      chan_event[0] && !capture_select[0]);
endmodule : tes_status
`default_nettype wire
